// *** rtl/tpw_ch_if.sv ***
// Bundle between the register front end and one PWM channel
`timescale 1ns/1ps
`default_nettype none
interface tpw_ch_if;
  logic run;
  logic tick;
  logic dbe;
  logic level;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic pin;
  logic ovf_irq;

  modport ctl (output run, tick, dbe, level, wr, wdata, input rdata, pin, ovf_irq);
  modport ch (input run, tick, dbe, level, wr, wdata, output rdata, pin, ovf_irq);
endinterface : tpw_ch_if
`default_nettype wire

// *** rtl/tpw_channel.sv ***
// One PWM channel: 128-count period, duty compare, extra pulse
`timescale 1ns/1ps
`default_nettype none
module tpw_channel #(
  parameter int CNT_W = tpw_pkg::TPW_DUTY_W
) (
  input wire logic pclk,
  input wire logic presetn,
  tpw_ch_if.ch cif
);
  import tpw_pkg::*;

  generate
    if (CNT_W != TPW_DUTY_W) begin : g_chk
      $error("tpw_channel: CNT_W must match the duty field width");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;
  logic even_r;
  logic out_r;
  logic irq_r;
  logic [7:0] buf_r;
  logic [7:0] act_r;

  // ----------------------------------------------------------------
  // Compare decode
  // ----------------------------------------------------------------
  wire [CNT_W-1:0] duty = act_r[TPW_DUTY_LO +: CNT_W];
  wire extra = act_r[TPW_EXTRA_BIT] & even_r;
  wire ovf = cif.tick & (cnt_r == {CNT_W{1'b1}});
  wire [CNT_W:0] cnt_inc = {1'b0, cnt_r} + {{CNT_W{1'b0}}, 1'b1};
  wire [CNT_W:0] match_pt = {1'b0, duty} + {{CNT_W{1'b0}}, extra};
  wire hit = cif.tick & ~ovf & (cnt_inc == match_pt);
  wire zero_next = (duty == '0) & ~(act_r[TPW_EXTRA_BIT] & ~even_r);
  wire direct_wr = cif.wr & cif.run & ~cif.dbe;
  wire wr_eq = direct_wr & (cif.wdata[TPW_DUTY_LO +: CNT_W] == cnt_r);

  assign cif.pin = out_r;
  assign cif.rdata = buf_r;
  assign cif.ovf_irq = irq_r;

  // ----------------------------------------------------------------
  // Counter, period parity and output
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      even_r <= 1'b0;
      out_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (!cif.run) begin
      cnt_r <= '0; // R10
      even_r <= 1'b0; // R17
      out_r <= cif.level; // R5 R10
      irq_r <= 1'b0;
    end else begin
      irq_r <= ovf & even_r; // R9 R16
      if (ovf) begin
        cnt_r <= '0; // R8
        even_r <= ~even_r;
        out_r <= zero_next ? ~cif.level : cif.level; // R8 R16
      end else if (cif.tick) begin
        cnt_r <= cnt_inc[CNT_W-1:0]; // R6
        if (hit) begin
          out_r <= ~cif.level; // R7 R4 R16
        end
      end else if (wr_eq) begin
        out_r <= ~cif.level; // R14
      end
    end
  end

  // ----------------------------------------------------------------
  // Duty holding buffer and active compare value
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= TPW_DUTY_RST;
      act_r <= TPW_DUTY_RST;
    end else begin
      if (cif.wr) begin
        buf_r <= cif.wdata; // R13
      end
      if (cif.wr && (!cif.run || !cif.dbe)) begin
        act_r <= cif.wdata; // R14 R15
      end else if (ovf && even_r && cif.dbe && cif.run) begin
        act_r <= buf_r; // R13
      end
    end
  end
endmodule : tpw_channel
`default_nettype wire

// *** rtl/tpw_pkg.sv ***
// Constants shared by the dual-channel 7-bit PWM block
`default_nettype none
package tpw_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] TPW_IDX_DUTY0 = 8'h28;
  localparam logic [7:0] TPW_IDX_DUTY1 = 8'h29;
  localparam logic [7:0] TPW_IDX_MODE0 = 8'h2a;
  localparam logic [7:0] TPW_IDX_MODE1 = 8'h2b;
  localparam logic [7:0] TPW_IDX_CTRL = 8'h2c;
  localparam logic [7:0] TPW_IDX_STAT = 8'h2d;
  localparam logic [7:0] TPW_IDX_MASK = 8'h2e;
  localparam int TPW_ADDR_W = 10;

  // ----------------------------------------------------------------
  // Timer mode register fields
  // ----------------------------------------------------------------
  localparam int TPW_MODE_LEVEL = 0;
  localparam int TPW_MODE_EXTIN = 1;
  localparam int TPW_MODE_OP_LO = 2;
  localparam int TPW_MODE_CLK_LO = 4;
  localparam int TPW_MODE_DBE = 7;
  localparam logic [1:0] TPW_OP_PWM = 2'h2;
  localparam logic [7:0] TPW_MODE_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timer control register fields
  // ----------------------------------------------------------------
  localparam int TPW_CTRL_RUN0 = 0;
  localparam int TPW_CTRL_RUN1 = 1;
  localparam int TPW_CTRL_CASCADE = 2;
  localparam int TPW_CTRL_AND = 3;
  localparam logic [3:0] TPW_CTRL_RST = 4'h0;

  // ----------------------------------------------------------------
  // Duty setting register and interrupt registers
  // ----------------------------------------------------------------
  localparam int TPW_DUTY_W = 7;
  localparam int TPW_DUTY_LO = 1;
  localparam int TPW_EXTRA_BIT = 0;
  localparam logic [7:0] TPW_DUTY_RST = 8'hff;
  localparam logic [1:0] TPW_IRQ_RST = 2'h0;

  // ----------------------------------------------------------------
  // Source clock divider: shift per clock select code, 4 bits each
  // ----------------------------------------------------------------
  localparam int TPW_DIV_W = 11;
  localparam logic [31:0] TPW_DIV_SHIFTS = 32'h012468ab;

endpackage : tpw_pkg
`default_nettype wire

// *** rtl/tpw_prescaler.sv ***
// Free-running divider giving a one-cycle source clock tick
`timescale 1ns/1ps
`default_nettype none
module tpw_prescaler #(
  parameter int DIV_W = tpw_pkg::TPW_DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  import tpw_pkg::*;

  generate
    if (DIV_W < 11) begin : g_chk
      $error("tpw_prescaler: DIV_W must be at least 11");
    end
  endgenerate

  logic [DIV_W-1:0] div_r;
  wire [3:0] shift = TPW_DIV_SHIFTS[{clk_sel, 2'b00} +: 4];
  wire [DIV_W-1:0] div_mask = DIV_W'((1 << shift) - 1);

  assign tick = (div_r & div_mask) == div_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
endmodule : tpw_prescaler
`default_nettype wire

// *** rtl/tpw_top.sv ***
// Dual-channel 7-bit PWM with extra pulse, APB register front end
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [R1] Software picks PWM mode, no cascade, internal clock
// [R2] Mode register writes ignored while running
// [R3] Duty bits 7..1, extra-pulse enable bit 0
// [R4] Even duty pulses stretched by one count
// [R5] Stopped pin shows initial level
// [R6] Counter advances once per source tick
// [R7] Duty match reverses pin away from level
// [R8] Count 128 overflows, clears, reverses pin back
// [R9] Interrupt only on even-numbered overflows
// [R10] Stop clears counter, restores initial level
// [R11] AND-combine drives both channels onto pin
// [R12] Second channel identical with own resources
// [R13] Double buffer loads at even overflow, reads buffer
// [R14] Unbuffered write acts at once while running
// [R15] Stopped write loads buffer and compare
// [R16] Edges and interrupt aligned to source tick
// [R17] Parity flag cleared on stop
module tpw_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpw_pkg::TPW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_out_pin_ch0,
  output logic pwm_out_pin_ch1,
  output logic timer_irq
);
  import tpw_pkg::*;

  localparam int NCH = 2;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] mode_r [NCH];
  logic [3:0] ctrl_r;
  logic [1:0] stat_r;
  logic [1:0] mask_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic irq_r;
  logic pin0_r;
  logic pin1_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire aligned = paddr[1:0] == 2'h0;
  wire [7:0] idx = paddr[TPW_ADDR_W-1:2];
  wire sel_duty0 = aligned & (idx == TPW_IDX_DUTY0);
  wire sel_duty1 = aligned & (idx == TPW_IDX_DUTY1);
  wire sel_mode0 = aligned & (idx == TPW_IDX_MODE0);
  wire sel_mode1 = aligned & (idx == TPW_IDX_MODE1);
  wire sel_ctrl = aligned & (idx == TPW_IDX_CTRL);
  wire sel_stat = aligned & (idx == TPW_IDX_STAT);
  wire sel_mask = aligned & (idx == TPW_IDX_MASK);
  wire mapped = sel_duty0 | sel_duty1 | sel_mode0 | sel_mode1 | sel_ctrl | sel_stat | sel_mask;

  // ----------------------------------------------------------------
  // Bus phases
  // ----------------------------------------------------------------
  wire access = psel & penable;
  wire done = access & pready_r;
  wire wr_en = done & pwrite & mapped;
  wire wr_duty0 = wr_en & sel_duty0;
  wire wr_duty1 = wr_en & sel_duty1;
  wire wr_mode0 = wr_en & sel_mode0;
  wire wr_mode1 = wr_en & sel_mode1;
  wire wr_ctrl = wr_en & sel_ctrl;
  wire wr_stat = wr_en & sel_stat;
  wire wr_mask = wr_en & sel_mask;

  // ----------------------------------------------------------------
  // Channel bundles
  // ----------------------------------------------------------------
  tpw_ch_if ch_if [NCH] ();

  wire [NCH-1:0] run_bit = {ctrl_r[TPW_CTRL_RUN1], ctrl_r[TPW_CTRL_RUN0]};
  wire [NCH-1:0] wr_duty = {wr_duty1, wr_duty0};
  wire [NCH-1:0] wr_mode = {wr_mode1, wr_mode0};
  wire cascade_select = ctrl_r[TPW_CTRL_CASCADE];
  wire and_combine = ctrl_r[TPW_CTRL_AND];
  wire [NCH-1:0] pwm_mode;
  wire [NCH-1:0] ch_pin;
  wire [NCH-1:0] ch_irq;
  wire [7:0] ch_rdata [NCH];

  // ----------------------------------------------------------------
  // Per-channel prescaler and PWM engine
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch // R12
      wire [2:0] clock_select = mode_r[i][TPW_MODE_CLK_LO +: 3];
      wire [1:0] op_mode_field = mode_r[i][TPW_MODE_OP_LO +: 2];
      wire ext_input_select = mode_r[i][TPW_MODE_EXTIN];
      wire src_tick;

      // Only the PWM setting lets the counter run
      assign pwm_mode[i] = (op_mode_field == TPW_OP_PWM) & ~cascade_select & ~ext_input_select; // R1

      tpw_prescaler u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clk_sel(clock_select),
        .tick(src_tick)
      );

      assign ch_if[i].run = run_bit[i] & pwm_mode[i];
      assign ch_if[i].tick = src_tick;
      assign ch_if[i].dbe = mode_r[i][TPW_MODE_DBE];
      assign ch_if[i].level = mode_r[i][TPW_MODE_LEVEL];
      assign ch_if[i].wr = wr_duty[i];
      assign ch_if[i].wdata = pwdata[7:0];
      assign ch_pin[i] = ch_if[i].pin;
      assign ch_irq[i] = ch_if[i].ovf_irq;
      assign ch_rdata[i] = ch_if[i].rdata;

      tpw_channel u_ch (
        .pclk(pclk),
        .presetn(presetn),
        .cif(ch_if[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire [31:0] rd_duty0 = {24'h000000, ch_rdata[0]}; // R3
  wire [31:0] rd_duty1 = {24'h000000, ch_rdata[1]};
  wire [31:0] rd_mode0 = {24'h000000, mode_r[0]};
  wire [31:0] rd_mode1 = {24'h000000, mode_r[1]};
  wire [31:0] rd_ctrl = {28'h0000000, ctrl_r};
  wire [31:0] rd_stat = {30'h0, stat_r};
  wire [31:0] rd_mask = {30'h0, mask_r};
  wire [31:0] rd_mux = sel_duty0 ? rd_duty0 :
                       sel_duty1 ? rd_duty1 :
                       sel_mode0 ? rd_mode0 :
                       sel_mode1 ? rd_mode1 :
                       sel_ctrl ? rd_ctrl :
                       sel_stat ? rd_stat :
                       sel_mask ? rd_mask : 32'h00000000;

  // ----------------------------------------------------------------
  // Interrupt status next value, set wins over clear
  // ----------------------------------------------------------------
  wire [1:0] stat_clr = wr_stat ? pwdata[1:0] : 2'h0;
  wire [1:0] stat_nxt = (stat_r & ~stat_clr) | ch_irq; // R9

  // ----------------------------------------------------------------
  // Output pin selection
  // ----------------------------------------------------------------
  wire pin0_nxt = and_combine ? (ch_pin[0] & ch_pin[1]) : ch_pin[0]; // R11

  // ----------------------------------------------------------------
  // APB handshake: one wait state, answer from registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (access && !pready_r) begin
      pready_r <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timer mode registers, frozen while the channel's run bit is set
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        mode_r[i] <= TPW_MODE_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_mode[i] && !run_bit[i]) begin
          mode_r[i] <= pwdata[7:0]; // R2
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= TPW_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= pwdata[3:0]; // R6 R10
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and line
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= TPW_IRQ_RST;
      mask_r <= TPW_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr_mask) begin
        mask_r <= pwdata[1:0];
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // Pin output flops
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin0_r <= 1'b0;
      pin1_r <= 1'b0;
    end else begin
      pin0_r <= pin0_nxt;
      pin1_r <= ch_pin[1];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pwm_out_pin_ch0 = pin0_r;
  assign pwm_out_pin_ch1 = pin1_r;
  assign timer_irq = irq_r;

endmodule : tpw_top
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the dual-channel PWM block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tpw_pkg::*;
  typedef struct {logic [9:0] a; logic [31:0] d; logic [31:0] q; logic e;} tpw_row_type;
  localparam logic [9:0] A_D0 = {TPW_IDX_DUTY0, 2'b00};
  localparam logic [9:0] A_D1 = {TPW_IDX_DUTY1, 2'b00};
  localparam logic [9:0] A_M0 = {TPW_IDX_MODE0, 2'b00};
  localparam logic [9:0] A_M1 = {TPW_IDX_MODE1, 2'b00};
  localparam logic [9:0] A_CT = {TPW_IDX_CTRL, 2'b00};
  localparam logic [9:0] A_ST = {TPW_IDX_STAT, 2'b00};
  localparam logic [9:0] A_MK = {TPW_IDX_MASK, 2'b00};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, pin0, pin1, irq, e;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_fail = 0;
  int n_tests = 0;
  int lo0, hi0, nr0, lo1, hi1, nr1;
  tpw_row_type rows[6];
  always #20 pclk = ~pclk;
  tpw_top i_tpw_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_out_pin_ch0(pin0), .pwm_out_pin_ch1(pin1), .timer_irq(irq));
  tpw_load l0 (.pclk(pclk), .pin(pin0), .lo_len(lo0), .hi_len(hi0), .n_rise(nr0));
  tpw_load l1 (.pclk(pclk), .pin(pin1), .lo_len(lo1), .hi_len(hi1), .n_rise(nr1));
  // ----------------------------------------------------------------
  // Bus master, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rise(input int ch, input int k);
    int t;
    int s;
    t = 0;
    s = ch ? nr1 : nr0;
    while ((ch ? nr1 : nr0) < s + k && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    if (t >= 3000) begin
      chk(32'(ch ? nr1 : nr0), 32'(s + k));
    end
  endtask : wait_rise
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h0;
    pwdata = 32'h0;
    rows = '{'{A_D0, 32'h55, 32'h55, 1'b0}, '{A_D1, 32'h2a, 32'h2a, 1'b0}, '{A_MK, 32'h3, 32'h3, 1'b0},
      '{10'h3fc, 32'hff, 32'h0, 1'b1}, '{A_D0 + 10'h1, 32'hff, 32'h0, 1'b1}, '{A_D0, 32'h1ff, 32'hff, 1'b0}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_D0, 32'h0);
    chk(q, 32'hff);
    chk(32'(pin0), 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      apb(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].q);
      chk(32'(e), 32'(rows[i].e));
    end
    apb(1'b1, A_M0, 32'h78);
    apb(1'b1, A_D0, 32'h29);
    apb(1'b1, A_MK, 32'h1);
    apb(1'b1, A_CT, 32'h1);
    wait_rise(0, 2);
    chk(32'(lo0), 32'd21);
    chk(32'(hi0), 32'd108);
    wait_rise(0, 1);
    chk(32'(lo0), 32'd20);
    chk(32'(hi0), 32'd107);
    chk(32'(irq), 32'h1);
    apb(1'b1, A_ST, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    wait_rise(0, 1);
    apb(1'b0, A_ST, 32'h0);
    chk(q, 32'h0);
    wait_rise(0, 1);
    apb(1'b0, A_ST, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, A_M0, 32'h79);
    apb(1'b1, A_CT, 32'h0);
    repeat (3) @(posedge pclk);
    chk(32'(pin0), 32'h0);
    apb(1'b1, A_M0, 32'h79);
    repeat (3) @(posedge pclk);
    chk(32'(pin0), 32'h1);
    apb(1'b1, A_M0, 32'h78);
    apb(1'b1, A_M1, 32'h78);
    apb(1'b1, A_D1, 32'h50);
    apb(1'b1, A_CT, 32'h3);
    wait_rise(1, 3);
    chk(32'(lo1), 32'd40);
    chk(32'(hi1), 32'd88);
    apb(1'b0, A_ST, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, A_CT, 32'hb);
    wait_rise(0, 2);
    chk(32'(lo0), 32'd40);
    apb(1'b1, A_CT, 32'h0);
    apb(1'b1, A_M0, 32'hf8);
    apb(1'b1, A_D0, 32'h29);
    apb(1'b1, A_CT, 32'h1);
    apb(1'b1, A_D0, 32'h51);
    apb(1'b0, A_D0, 32'h0);
    chk(q, 32'h51);
    wait_rise(0, 2);
    chk(32'(lo0), 32'd21);
    chk(32'(hi0), 32'd108);
    wait_rise(0, 1);
    chk(32'(lo0), 32'd40);
    apb(1'b1, A_CT, 32'h0);
    apb(1'b1, A_M0, 32'h68);
    apb(1'b1, A_CT, 32'h1);
    apb(1'b1, A_D0, 32'h3c);
    wait_rise(0, 2);
    chk(32'(hi0), 32'd196);
    chk(32'(lo0), 32'd60);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_D0, 32'h0);
    chk(q, 32'hff);
    chk(32'(irq), 32'h0);
    chk(32'(pin0), 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire

// *** testbench/tpw_chk.sv ***
// Port-level assertions for the dual-channel PWM block
`timescale 1ns/1ps
`default_nettype none
module tpw_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpw_pkg::TPW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_out_pin_ch0,
  input wire logic pwm_out_pin_ch1,
  input wire logic timer_irq
);
  import tpw_pkg::*;

  logic wr_done;
  logic [3:0] ctrl_r;
  logic lvl0_r;
  logic [1:0] mask_r;
  assign wr_done = psel && penable && pready && pwrite;
  // ----------------------------------------------------------------
  // Shadow of control, level and mask as written by software
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 4'h0;
      lvl0_r <= 1'b0;
      mask_r <= 2'h0;
    end else if (wr_done) begin
      if (paddr == {TPW_IDX_CTRL, 2'b00}) ctrl_r <= pwdata[3:0];
      if (paddr == {TPW_IDX_MASK, 2'b00}) mask_r <= pwdata[1:0];
      if (paddr == {TPW_IDX_MODE0, 2'b00} && !ctrl_r[0]) lvl0_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_unmapped_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access without error");
  err_data_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("error response malformed");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  idle_level_a: assert property (
    (!ctrl_r[0] && !ctrl_r[3] && $stable(lvl0_r))[*3] |-> pwm_out_pin_ch0 == lvl0_r)
    else $error("stopped pin not at initial level");
  irq_mask_a: assert property (timer_irq |-> $past(mask_r) != 2'h0)
    else $error("interrupt with all sources masked");
  and_combine_a: assert property (
    ctrl_r[3] && $past(ctrl_r[3], 2) && pwm_out_pin_ch0 |-> pwm_out_pin_ch1)
    else $error("combined pin high while channel 1 low");
  cover property (pslverr);
  cover property (timer_irq);
  cover property (ctrl_r[3] && pwm_out_pin_ch0);
endmodule : tpw_chk
bind tpw_top tpw_chk i_tpw_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pwm_out_pin_ch0(pwm_out_pin_ch0), .pwm_out_pin_ch1(pwm_out_pin_ch1), .timer_irq(timer_irq));
`default_nettype wire

// *** testbench/tpw_load.sv ***
// External load on one PWM pin, measuring low and high run lengths
`timescale 1ns/1ps
`default_nettype none
module tpw_load (
  input wire logic pclk,
  input wire logic pin,
  output int lo_len,
  output int hi_len,
  output int n_rise
);
  int run_len;
  logic last;
  // ----------------------------------------------------------------
  // A passive load: it only counts pclk samples of each level and rising edges
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    last <= pin;
    run_len <= (pin !== last) ? 1 : run_len + 1;
    if (pin === 1'b1 && last === 1'b0) begin
      lo_len <= run_len;
      n_rise <= n_rise + 1;
    end
    if (pin === 1'b0 && last === 1'b1) begin
      hi_len <= run_len;
    end
  end
endmodule : tpw_load
`default_nettype wire
